/* File: src/eiec_edge_catch.sv */
// Purpose: catch rising and falling edges of one line, however short
// Assumes: line input may pulse for less than one clock period; resetn synchronous to clock
// Notes: toggles run on the line itself and cross by two flip-flops
`timescale 1ns/10ps
`default_nettype none
module eiec_edge_catch (
    input wire logic clock,
    input wire logic resetn,
    input wire logic lineIn,
    output logic riseSeen,
    output logic fallSeen
);
    logic riseTog_reg;
    logic fallTog_reg;
    logic [2:0] riseSync_reg;
    logic [2:0] fallSync_reg;
    logic [2:0] riseSync_next;
    logic [2:0] fallSync_next;

    ////////////////////////////////////////////////////////////////////////////
    // Toggle per edge, clocked by the line itself
    always_ff @(posedge lineIn or negedge resetn) begin
        if (!resetn) begin
            riseTog_reg <= 1'b0;
        end else begin
            riseTog_reg <= ~riseTog_reg;
        end
    end

    always_ff @(negedge lineIn or negedge resetn) begin
        if (!resetn) begin
            fallTog_reg <= 1'b0;
        end else begin
            fallTog_reg <= ~fallTog_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser plus one history stage
    always_comb begin
        riseSync_next = {riseSync_reg[1:0], riseTog_reg};
        fallSync_next = {fallSync_reg[1:0], fallTog_reg};
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            riseSync_reg <= 3'h0;
            fallSync_reg <= 3'h0;
        end else begin
            riseSync_reg <= riseSync_next;
            fallSync_reg <= fallSync_next;
        end
    end

    // One-cycle pulse per toggle seen
    assign riseSeen = riseSync_reg[1] ^ riseSync_reg[2];
    assign fallSeen = fallSync_reg[1] ^ fallSync_reg[2];
endmodule
`default_nettype wire

/* File: src/eiec_pkg.sv */
// Purpose: shared constants of the external edge event controller
// Assumes: APB register map with 32-bit aligned words
// Notes: all offsets are byte addresses
`default_nettype none
package eiec_pkg;
    // Line counts
    localparam int NUM_LINES = 23;
    localparam int EXT_LINES = 16;
    localparam int GPIO_COUNT = 140;
    localparam int SEL_W = 8;
    localparam int SEL_PER_WORD = 4;
    // Register offsets
    localparam logic [11:0] OFS_IRQ_MASK = 12'h000;
    localparam logic [11:0] OFS_EVT_MASK = 12'h004;
    localparam logic [11:0] OFS_RISE_EN = 12'h008;
    localparam logic [11:0] OFS_FALL_EN = 12'h00C;
    localparam logic [11:0] OFS_PENDING = 12'h010;
    localparam logic [11:0] OFS_PIN_SEL0 = 12'h014;
    localparam logic [11:0] OFS_PIN_SEL3 = 12'h020;
    localparam logic [11:0] OFS_INT_STAT = 12'h024;
    localparam logic [11:0] OFS_INT_MASK = 12'h028;
    // Reset values
    localparam logic [NUM_LINES-1:0] RST_LINE_REG = 23'h000000;
    localparam logic [SEL_W-1:0] RST_PIN_SEL = 8'h00;
endpackage
`default_nettype wire

/* File: src/eiec_top.sv */
// Purpose: external edge event controller with APB register access
// Assumes: 25 MHz clock, synchronous active-low reset, APB slave
// Notes: request outputs go toward the core interrupt controller
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module eiec_top #(
    parameter int NUM_LINES = eiec_pkg::NUM_LINES,
    parameter int EXT_LINES = eiec_pkg::EXT_LINES,
    parameter int GPIO_COUNT = eiec_pkg::GPIO_COUNT
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [GPIO_COUNT-1:0] gpioIn,
    input wire logic [NUM_LINES-EXT_LINES-1:0] internalIn,
    output logic [NUM_LINES-1:0] irqReq,
    output logic [NUM_LINES-1:0] evtReq,
    output logic irq
);
    localparam int SW = eiec_pkg::SEL_W;

    logic [NUM_LINES-1:0] irqMask_reg, irqMask_next;
    logic [NUM_LINES-1:0] evtMask_reg, evtMask_next;
    logic [NUM_LINES-1:0] riseEn_reg, riseEn_next;
    logic [NUM_LINES-1:0] fallEn_reg, fallEn_next;
    logic [NUM_LINES-1:0] pending_reg, pending_next;
    logic [NUM_LINES-1:0] intStat_reg, intStat_next;
    logic [NUM_LINES-1:0] intMask_reg, intMask_next;
    logic [SW-1:0] pinSel_reg [EXT_LINES];
    logic [SW-1:0] pinSel_next [EXT_LINES];
    logic [NUM_LINES-1:0] irqReq_reg, irqReq_next;
    logic [NUM_LINES-1:0] evtReq_reg, evtReq_next;
    logic irq_reg, irq_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [NUM_LINES-1:0] lineSrc;
    logic [NUM_LINES-1:0] riseSeen;
    logic [NUM_LINES-1:0] fallSeen;
    logic [NUM_LINES-1:0] trig;
    logic access;
    logic wrDone;
    logic rdDone;

    // Picks one pin from the pin vector, out of range reads low
    function automatic logic pickPin(input logic [GPIO_COUNT-1:0] pins,
                                     input logic [SW-1:0] sel);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < GPIO_COUNT; k++) begin
            if (sel == SW'(k)) begin
                hit = pins[k];
            end
        end
        return hit;
    endfunction

    // Pads a line vector into one bus word
    function automatic logic [31:0] toWord(input logic [NUM_LINES-1:0] v);
        return {{(32-NUM_LINES){1'b0}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Line sources and edge catchers
    always_comb begin
        lineSrc = '0;
        for (int i = 0; i < EXT_LINES; i++) begin
            lineSrc[i] = pickPin(gpioIn, pinSel_reg[i]);
        end
        lineSrc[NUM_LINES-1:EXT_LINES] = internalIn;
    end

    for (genvar g = 0; g < NUM_LINES; g++) begin : gLine
        eiec_edge_catch uCatch (
            .clock(clock),
            .resetn(resetn),
            .lineIn(lineSrc[g]),
            .riseSeen(riseSeen[g]),
            .fallSeen(fallSeen[g])
        );
    end

    // Qualified trigger per line
    assign trig = (riseSeen & riseEn_reg) | (fallSeen & fallEn_reg);

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake, answer one cycle into the access phase
    assign access = psel && penable && !pready_reg;
    assign wrDone = psel && penable && pready_reg && pwrite;
    assign rdDone = psel && penable && pready_reg && !pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // Register next values
    always_comb begin
        irqMask_next = irqMask_reg;
        evtMask_next = evtMask_reg;
        riseEn_next = riseEn_reg;
        fallEn_next = fallEn_reg;
        intMask_next = intMask_reg;
        pinSel_next = pinSel_reg;
        pending_next = pending_reg;
        intStat_next = intStat_reg;
        if (wrDone) begin
            unique case (paddr)
                eiec_pkg::OFS_IRQ_MASK: irqMask_next = pwdata[NUM_LINES-1:0];
                eiec_pkg::OFS_EVT_MASK: evtMask_next = pwdata[NUM_LINES-1:0];
                eiec_pkg::OFS_RISE_EN: riseEn_next = pwdata[NUM_LINES-1:0];
                eiec_pkg::OFS_FALL_EN: fallEn_next = pwdata[NUM_LINES-1:0];
                eiec_pkg::OFS_PENDING: pending_next = pending_reg & ~pwdata[NUM_LINES-1:0];
                eiec_pkg::OFS_INT_MASK: intMask_next = pwdata[NUM_LINES-1:0];
                default: begin
                    for (int w = 0; w < EXT_LINES / eiec_pkg::SEL_PER_WORD; w++) begin
                        if (paddr == eiec_pkg::OFS_PIN_SEL0 + 12'(4 * w)) begin
                            for (int f = 0; f < eiec_pkg::SEL_PER_WORD; f++) begin
                                pinSel_next[w * eiec_pkg::SEL_PER_WORD + f] =
                                    pwdata[f * SW +: SW];
                            end
                        end
                    end
                end
            endcase
        end
        if (rdDone && paddr == eiec_pkg::OFS_INT_STAT) begin
            intStat_next = intStat_reg & ~prdata_reg[NUM_LINES-1:0]; // Clear only what was read
        end
        pending_next = pending_next | trig;
        intStat_next = intStat_next | trig;
    end

    // Outputs toward the core, and the bus answer
    always_comb begin
        irqReq_next = pending_next & irqMask_next;
        evtReq_next = trig & evtMask_reg;
        irq_next = |(intStat_next & intMask_next);
        pready_next = access;
        pslverr_next = 1'b0;
        prdata_next = 32'h00000000;
        if (access) begin
            unique case (paddr)
                eiec_pkg::OFS_IRQ_MASK: prdata_next = toWord(irqMask_reg);
                eiec_pkg::OFS_EVT_MASK: prdata_next = toWord(evtMask_reg);
                eiec_pkg::OFS_RISE_EN: prdata_next = toWord(riseEn_reg);
                eiec_pkg::OFS_FALL_EN: prdata_next = toWord(fallEn_reg);
                eiec_pkg::OFS_PENDING: prdata_next = toWord(pending_reg);
                eiec_pkg::OFS_INT_STAT: prdata_next = toWord(intStat_reg);
                eiec_pkg::OFS_INT_MASK: prdata_next = toWord(intMask_reg);
                default: begin
                    pslverr_next = 1'b1;
                    for (int w = 0; w < EXT_LINES / eiec_pkg::SEL_PER_WORD; w++) begin
                        if (paddr == eiec_pkg::OFS_PIN_SEL0 + 12'(4 * w)) begin
                            pslverr_next = 1'b0;
                            for (int f = 0; f < eiec_pkg::SEL_PER_WORD; f++) begin
                                prdata_next[f * SW +: SW] =
                                    pinSel_reg[w * eiec_pkg::SEL_PER_WORD + f];
                            end
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irqMask_reg <= eiec_pkg::RST_LINE_REG;
            evtMask_reg <= eiec_pkg::RST_LINE_REG;
            riseEn_reg <= eiec_pkg::RST_LINE_REG;
            fallEn_reg <= eiec_pkg::RST_LINE_REG;
            pending_reg <= eiec_pkg::RST_LINE_REG;
            intStat_reg <= eiec_pkg::RST_LINE_REG;
            intMask_reg <= eiec_pkg::RST_LINE_REG;
            for (int i = 0; i < EXT_LINES; i++) begin
                pinSel_reg[i] <= eiec_pkg::RST_PIN_SEL;
            end
            irqReq_reg <= '0;
            evtReq_reg <= '0;
            irq_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            irqMask_reg <= irqMask_next;
            evtMask_reg <= evtMask_next;
            riseEn_reg <= riseEn_next;
            fallEn_reg <= fallEn_next;
            pending_reg <= pending_next;
            intStat_reg <= intStat_next;
            intMask_reg <= intMask_next;
            pinSel_reg <= pinSel_next;
            irqReq_reg <= irqReq_next;
            evtReq_reg <= evtReq_next;
            irq_reg <= irq_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Ports straight from flip-flops
    assign irqReq = irqReq_reg;
    assign evtReq = evtReq_reg;
    assign irq = irq_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
endmodule
`default_nettype wire

/* File: testbench/edge_interrupt_event_lines_tb.sv */
// Purpose: register-level test of the external edge event controller
// Assumes: one wait state per access, line latency under 5 cycles
// Notes: pins come from the pin model, internal lines from the bench
`timescale 1ns/10ps
`default_nettype none
module edge_interrupt_event_lines_tb;
    logic clock, resetn, psel, penable, pwrite, pready, pslverr, irq;
    logic cmdValid, cmdShort;
    logic [7:0] cmdPin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [139:0] gpioIn;
    logic [6:0] internalIn;
    logic [22:0] irqReq, evtReq;
    int err_total, samples_checked, evtCount, evtOther;
    logic [11:0] regs [8] = '{eiec_pkg::OFS_IRQ_MASK, eiec_pkg::OFS_EVT_MASK,
        eiec_pkg::OFS_RISE_EN, eiec_pkg::OFS_FALL_EN, eiec_pkg::OFS_PENDING,
        eiec_pkg::OFS_PIN_SEL0, eiec_pkg::OFS_INT_STAT, eiec_pkg::OFS_INT_MASK};
    eiec_top i_eiec_top (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gpioIn(gpioIn), .internalIn(internalIn), .irqReq(irqReq),
        .evtReq(evtReq), .irq(irq));
    eiec_pin_model i_eiec_pin_model (.clock(clock), .cmdValid(cmdValid),
        .cmdShort(cmdShort), .cmdPin(cmdPin), .gpioIn(gpioIn));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, event pulse count on line 0 and on lines 22 to 1
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        if (evtReq[0] === 1'b1) evtCount++;
        if ((|evtReq[22:1]) !== 1'b0) evtOther++;
    end
    task automatic give_verdict();
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; reads compare data, both compare the error flag
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] exp, input logic expErr);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("MISMATCH %0t no ready within bound", $time);
            give_verdict();
        end
        if (!w) check(prdata, exp);
        check({31'h0, pslverr}, {31'h0, expErr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    // Pin command to the model, then time for the line to settle
    task automatic pin(input logic [7:0] p, input logic s);
        cmdValid <= 1'b1;
        cmdPin <= p;
        cmdShort <= s;
        @(posedge clock);
        cmdValid <= 1'b0;
        repeat (5) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {psel, penable, pwrite, cmdValid, cmdShort, resetn} = '0;
        {paddr, pwdata, cmdPin, internalIn} = '0;
        {err_total, samples_checked, evtCount, evtOther} = '0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        foreach (regs[i]) xfer(1'b0, regs[i], 32'h0, 32'h0, 1'b0);
        xfer(1'b0, 12'h030, 32'h0, 32'h0, 1'b1);
        xfer(1'b1, 12'h02C, 32'hFFFFFFFF, 32'h0, 1'b1);
        xfer(1'b1, eiec_pkg::OFS_PIN_SEL0, 32'h00078B05, 32'h0, 1'b0);
        xfer(1'b1, eiec_pkg::OFS_RISE_EN, 32'h00010005, 32'h0, 1'b0);
        xfer(1'b1, eiec_pkg::OFS_FALL_EN, 32'h00000006, 32'h0, 1'b0);
        xfer(1'b1, eiec_pkg::OFS_IRQ_MASK, 32'h1, 32'h0, 1'b0);
        xfer(1'b1, eiec_pkg::OFS_EVT_MASK, 32'h1, 32'h0, 1'b0);
        xfer(1'b1, eiec_pkg::OFS_INT_MASK, 32'h4, 32'h0, 1'b0);
        pin(8'd5, 1'b0);
        pin(8'd139, 1'b0);
        pin(8'd7, 1'b0);
        xfer(1'b0, eiec_pkg::OFS_PENDING, 32'h0, 32'h5, 1'b0);
        check({9'h0, irqReq}, 32'h1);
        check(evtCount, 32'h1);
        check({31'h0, irq}, 32'h1);
        xfer(1'b0, eiec_pkg::OFS_INT_STAT, 32'h0, 32'h5, 1'b0);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        xfer(1'b0, eiec_pkg::OFS_INT_STAT, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, eiec_pkg::OFS_PENDING, 32'h0, 32'h5, 1'b0);
        xfer(1'b1, eiec_pkg::OFS_PENDING, 32'h5, 32'h0, 1'b0);
        xfer(1'b0, eiec_pkg::OFS_PENDING, 32'h0, 32'h0, 1'b0);
        pin(8'd5, 1'b0);
        pin(8'd139, 1'b0);
        pin(8'd7, 1'b0);
        xfer(1'b0, eiec_pkg::OFS_PENDING, 32'h0, 32'h6, 1'b0);
        check({9'h0, irqReq}, 32'h0);
        check({31'h0, irq}, 32'h1);
        xfer(1'b1, eiec_pkg::OFS_INT_MASK, 32'h0, 32'h0, 1'b0);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        pin(8'd5, 1'b1);
        xfer(1'b0, eiec_pkg::OFS_PENDING, 32'h0, 32'h7, 1'b0);
        check(evtCount, 32'h2);
        check({9'h0, irqReq}, 32'h1);
        internalIn[0] <= 1'b1;
        repeat (5) @(posedge clock);
        xfer(1'b0, eiec_pkg::OFS_PENDING, 32'h0, 32'h10007, 1'b0);
        check(evtOther, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: testbench/eiec_pin_model.sv */
// Purpose: general-purpose pins that feed the edge lines
// Assumes: commands arrive one at a time from the bench
// Notes: a short glitch is narrower than one clock period
`timescale 1ns/10ps
`default_nettype none
module eiec_pin_model #(
    parameter int GPIO_COUNT = 140
) (
    input wire logic clock,
    input wire logic cmdValid,
    input wire logic cmdShort,
    input wire logic [7:0] cmdPin,
    output var logic [GPIO_COUNT-1:0] gpioIn
);
    initial gpioIn = '0;
    // Level toggle, or a 15 ns high glitch on a low pin
    always @(posedge clock) begin
        if (cmdValid && cmdShort) begin
            #7 gpioIn[cmdPin] = 1'b1;
            #15 gpioIn[cmdPin] = 1'b0;
        end else if (cmdValid) begin
            gpioIn[cmdPin] <= ~gpioIn[cmdPin];
        end
    end
endmodule
`default_nettype wire

/* File: testbench/eiec_top_props.sv */
// Purpose: port checks for the external edge event controller
// Assumes: one clock, synchronous active-low reset
// Notes: bound onto eiec_top, sees its ports only
`timescale 1ns/10ps
`default_nettype none
module eiec_top_props #(
    parameter int NUM_LINES = 23,
    parameter int EXT_LINES = 16,
    parameter int GPIO_COUNT = 140
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [GPIO_COUNT-1:0] gpioIn,
    input wire logic [NUM_LINES-EXT_LINES-1:0] internalIn,
    input wire logic [NUM_LINES-1:0] irqReq,
    input wire logic [NUM_LINES-1:0] evtReq,
    input wire logic irq
);
    logic [3:0] wrAge_reg, wrAge_next, accAge_reg, accAge_next;
    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the last finished write and the last finished access
    always_comb begin
        wrAge_next = (wrAge_reg == 4'hF) ? wrAge_reg : wrAge_reg + 4'h1;
        accAge_next = (accAge_reg == 4'hF) ? accAge_reg : accAge_reg + 4'h1;
        if (psel && penable && pready) begin
            accAge_next = 4'h0;
            wrAge_next = pwrite ? 4'h0 : wrAge_next;
        end
    end
    always_ff @(posedge clock) begin
        wrAge_reg <= resetn ? wrAge_next : 4'hF;
        accAge_reg <= resetn ? accAge_next : 4'hF;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("ready without access");
    err_only_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    pend_hold_a: assert property (|($past(irqReq) & ~irqReq) |-> wrAge_reg <= 4'h3)
        else $error("request dropped without a write");
    irq_hold_a: assert property ($fell(irq) |-> accAge_reg <= 4'h3)
        else $error("interrupt dropped without an access");
    reset_quiet_a: assert property ($rose(resetn) |-> !irq && irqReq == '0 && evtReq == '0)
        else $error("outputs active after reset");
endmodule
bind eiec_top eiec_top_props #(.NUM_LINES(NUM_LINES), .EXT_LINES(EXT_LINES),
    .GPIO_COUNT(GPIO_COUNT)) i_eiec_top_props (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gpioIn(gpioIn), .internalIn(internalIn),
    .irqReq(irqReq), .evtReq(evtReq), .irq(irq));
`default_nettype wire
